// ### rtl/rsc_top.sv
// Reset source control: cause capture, source gating and register slave.
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
module rsc_top #(
  parameter int MCD_CYCLES = rsc_pkg::MCD_TIMEOUT_PS / rsc_pkg::CLK_PERIOD_PS
) (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic [9:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  input  wire logic               pin_reset_n,
  input  wire logic               suspend_mode,
  input  wire logic               sleep_mode,
  input  wire logic               clock_monitor,
  input  wire logic               comparator_out,
  input  wire logic               comparator_wake_en,
  input  wire logic               watchdog_overflow,
  input  wire rsc_pkg::rsc_flash_s flash_access,
  input  wire rsc_pkg::rsc_rtc_s  rtc_event,
  input  wire logic               supply_monitor_on,
  input  wire logic               supply_level_status,
  output logic                    sys_reset_q,
  output logic [7:0]              reset_flags_q,
  output logic                    watchdog_en_q,
  output logic                    watchdog_tick_q
);

  // Sequencer state and the cause captured on entry to reset.
  rsc_pkg::rsc_state_e state_q;
  logic [7:0]  cause_q;        // One-hot cause of the pending reset.
  logic [4:0]  hold_q;         // Cycles left of the least reset width.
  // Source enables written by software.
  logic        mcd_en_q;       // Clock-loss detector enable.
  logic        cmp_en_q;       // Comparator reset enable.
  logic        rtc_en_q;       // Real-time-clock reset enable.
  logic        por_en_q;       // Supply monitor reset enable.
  logic        sw_force_q;     // Software reset request, one cycle.
  // Clock-loss detector state and watchdog divider.
  logic        mon_prev_q;     // Last sampled level of the clock.
  logic [31:0] mcd_cnt_q;      // Cycles since the last clock edge.
  logic [3:0]  div_q;          // Watchdog clock divider.
  // Bus handshake helpers.
  logic        ack_q;          // Answer cycle of an access.
  logic        wr_ok;          // Write takes effect this edge.
  logic        cause_sel;      // Address hits the cause register.
  logic        aux_sel;        // Address hits the auxiliary register.
  // Combinational source requests.
  logic        low_power;
  logic        mcd_trip;
  logic        cmp_trip;
  logic        wdt_trip;
  logic        flash_trip;
  logic        rtc_trip;
  logic        por_trip;
  logic [7:0]  cause_d;
  logic        level_busy;

  assign low_power = suspend_mode | sleep_mode;
  assign cause_sel = avs_address == rsc_pkg::CAUSE_ADDR;
  assign aux_sel   = avs_address == rsc_pkg::AUX_ADDR;
  assign wr_ok     = avs_write & ack_q & avs_byteenable[0];

  // Source requests; the stored enables are never altered by low power,
  // so they come back unchanged when the device wakes.
  always_comb begin
    mcd_trip   = mcd_en_q & ~low_power
                 & (mcd_cnt_q >= 32'(MCD_CYCLES));
    cmp_trip   = cmp_en_q & ~comparator_out
                 & (~low_power | comparator_wake_en);
    wdt_trip   = watchdog_en_q & ~low_power
                 & watchdog_overflow;
    flash_trip = (flash_access.write_attempt
                  & flash_access.write_enable
                  & flash_access.write_above)
                 | flash_access.table_above
                 | flash_access.branch_above
                 | flash_access.security_block
                 | (flash_access.write_attempt & ~supply_monitor_on);
    rtc_trip   = rtc_en_q
                 & ((rtc_event.osc_mon_en & rtc_event.clk_slow)
                    | (rtc_event.alarm_en & rtc_event.alarm_match));
    por_trip   = por_en_q & supply_monitor_on
                 & ~supply_level_status;
  end

  // Fixed priority picks one cause when several strike together.
  always_comb begin
    cause_d = 8'h00;
    if (!pin_reset_n) begin
      cause_d[rsc_pkg::PIN_BIT] = 1'b1;
    end else if (por_trip) begin
      cause_d[rsc_pkg::POR_BIT] = 1'b1;
    end else if (mcd_trip) begin
      cause_d[rsc_pkg::MCD_BIT] = 1'b1;
    end else if (wdt_trip) begin
      cause_d[rsc_pkg::WDT_BIT] = 1'b1;
    end else if (flash_trip) begin
      cause_d[rsc_pkg::FLASH_BIT] = 1'b1;
    end else if (rtc_trip) begin
      cause_d[rsc_pkg::RTC_BIT] = 1'b1;
    end else if (cmp_trip) begin
      cause_d[rsc_pkg::CMP_BIT] = 1'b1;
    end else if (sw_force_q) begin
      cause_d[rsc_pkg::SW_BIT] = 1'b1;
    end
  end

  // Only the pin keeps the device in reset while it stays low; the comparator and supply terms drop once reset clears their enables.
  assign level_busy = ~pin_reset_n | cmp_trip | por_trip;

  // Reset sequencer. Only the reset request output is driven; there is
  // no path back to the pin, so internal causes leave it untouched.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q     <= rsc_pkg::RSC_RUN;
      sys_reset_q <= 1'b0;
      cause_q     <= 8'h00;
      hold_q      <= 5'h00;
    end else begin
      case (state_q)
        rsc_pkg::RSC_RUN: begin
          if (|cause_d) begin
            state_q     <= rsc_pkg::RSC_HOLD;
            sys_reset_q <= 1'b1;
            cause_q     <= cause_d;
            hold_q      <= rsc_pkg::HOLD_LAST;
          end
        end
        rsc_pkg::RSC_HOLD: begin
          if (hold_q != 5'h00) begin
            hold_q <= hold_q - 5'h01;
          end else if (!level_busy) begin
            state_q     <= rsc_pkg::RSC_RUN;
            sys_reset_q <= 1'b0;
          end
        end
        default: begin
          state_q     <= rsc_pkg::RSC_RUN;
          sys_reset_q <= 1'b0;
        end
      endcase
    end
  end

  // Cause flags load on exit from reset, so each flag reads 1 only after
  // its own cause and 0 after any other. Power-on shows the supply flag.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reset_flags_q <= rsc_pkg::POR_FLAGS;
    end else if (state_q == rsc_pkg::RSC_HOLD && hold_q == 5'h00
                 && !level_busy) begin
      reset_flags_q <= cause_q;
    end
  end

  // Software enables. A system reset returns them to off; software
  // must set them again, which also keeps settle time under its control.
  always_ff @(posedge clk) begin
    if (!rstn || sys_reset_q) begin
      mcd_en_q   <= 1'b0;
      cmp_en_q   <= 1'b0;
      rtc_en_q   <= 1'b0;
      por_en_q   <= 1'b0;
      sw_force_q <= 1'b0;
    end else begin
      sw_force_q <= wr_ok & cause_sel
                    & avs_writedata[rsc_pkg::SW_BIT];
      if (wr_ok && cause_sel) begin
        mcd_en_q <= avs_writedata[rsc_pkg::MCD_BIT];
        cmp_en_q <= avs_writedata[rsc_pkg::CMP_BIT];
        rtc_en_q <= avs_writedata[rsc_pkg::RTC_BIT];
        por_en_q <= avs_writedata[rsc_pkg::POR_BIT];
      end
    end
  end

  // Watchdog enable is forced on by every reset; software may clear it.
  always_ff @(posedge clk) begin
    if (!rstn || sys_reset_q) begin
      watchdog_en_q <= 1'b1;
    end else if (wr_ok && aux_sel) begin
      watchdog_en_q <= avs_writedata[rsc_pkg::AUX_WDT_BIT];
    end
  end

  // Watchdog time base: one tick every twelve system clocks.
  always_ff @(posedge clk) begin
    if (!rstn || sys_reset_q) begin
      div_q           <= 4'h0;
      watchdog_tick_q <= 1'b0;
    end else begin
      div_q           <= (div_q == rsc_pkg::WDT_LAST) ? 4'h0 : div_q + 4'h1;
      watchdog_tick_q <= watchdog_en_q
                         & (div_q == rsc_pkg::WDT_LAST);
    end
  end

  // Clock-loss one-shot: any change of the monitored clock restarts the
  // count. It saturates so a long stall cannot wrap and hide itself.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mon_prev_q <= 1'b0;
      mcd_cnt_q  <= 32'h0;
    end else begin
      mon_prev_q <= clock_monitor;
      if (clock_monitor != mon_prev_q || !mcd_en_q || low_power) begin
        mcd_cnt_q <= 32'h0;
      end else if (mcd_cnt_q < 32'(MCD_CYCLES)) begin
        mcd_cnt_q <= mcd_cnt_q + 32'h1;
      end
    end
  end

  // Avalon slave: every access is answered one cycle after it is seen.
  // Unmapped reads return zero and unmapped writes are dropped.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ack_q           <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else begin
      ack_q           <= (avs_read | avs_write) & ~ack_q;
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack_q);
      if (avs_read && !ack_q) begin
        if (cause_sel) begin
          // When the supply flag is set the other bits carry no meaning.
          avs_readdata <= {24'h0, reset_flags_q};
        end else if (aux_sel) begin
          avs_readdata <= {30'h0, low_power, watchdog_en_q};
        end else begin
          avs_readdata <= 32'h0;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  pin_reset_a: assert property (!pin_reset_n |=> sys_reset_q)
    else $error("Pin low did not hold reset.");
  sleep_pin_a: assert property (low_power && !pin_reset_n ##1 low_power
    |-> sys_reset_q)
    else $error("Pin reset lost in low power.");
  flag_load_a: assert property ($fell(sys_reset_q)
    |-> reset_flags_q == $past(cause_q))
    else $error("Flags differ from captured cause.");
  mcd_fire_a: assert property (state_q == rsc_pkg::RSC_RUN && mcd_trip
    |=> sys_reset_q && cause_q != 8'h00)
    else $error("Clock-loss timeout gave no reset.");
  mcd_sleep_a: assert property (low_power |=> mcd_cnt_q == 32'h0)
    else $error("Clock-loss detector active in low power.");
  wdt_sleep_a: assert property (low_power |-> !wdt_trip)
    else $error("Watchdog active in low power.");
  cmp_fire_a: assert property (state_q == rsc_pkg::RSC_RUN && cmp_en_q
    && !comparator_out && !low_power |=> sys_reset_q)
    else $error("Comparator low gave no reset.");
  wdt_on_a: assert property ($fell(sys_reset_q) |-> watchdog_en_q)
    else $error("Watchdog not enabled after reset.");
  sw_force_a: assert property (wr_ok && cause_sel
    && avs_writedata[rsc_pkg::SW_BIT] && state_q == rsc_pkg::RSC_RUN
    |-> ##[1:2] sys_reset_q)
    else $error("Software force gave no reset.");
  bus_ack_a: assert property ((avs_read || avs_write) && avs_waitrequest
    && !ack_q |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("Bus answer not one cycle wide.");

  pin_cycle_c: cover property (!pin_reset_n ##1 sys_reset_q
    ##[1:40] !sys_reset_q);
  wdt_cycle_c: cover property (wdt_trip ##[1:40] $fell(sys_reset_q));
  flash_cycle_c: cover property (flash_trip ##[1:40] $fell(sys_reset_q));

endmodule

// ### rtl/rsc_pkg.sv
// Package with register map, field positions and timing for reset sources.
package rsc_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [7:0] CAUSE_IDX    = 8'hef;  // Reset cause and enable.
  localparam logic [7:0] AUX_IDX      = 8'hf0;  // Watchdog enable and status.
  localparam logic [9:0] CAUSE_ADDR   = {CAUSE_IDX, 2'h0};
  localparam logic [9:0] AUX_ADDR     = {AUX_IDX, 2'h0};
  // Bit positions inside the reset cause and enable register.
  localparam int PIN_BIT   = 0;  // External pin reset flag.
  localparam int POR_BIT   = 1;  // Power-on / supply monitor flag and enable.
  localparam int MCD_BIT   = 2;  // Clock-loss detector flag and enable.
  localparam int WDT_BIT   = 3;  // Watchdog flag.
  localparam int SW_BIT    = 4;  // Software reset force and flag.
  localparam int CMP_BIT   = 5;  // Comparator flag and enable.
  localparam int FLASH_BIT = 6;  // Flash error flag.
  localparam int RTC_BIT   = 7;  // Real-time-clock flag and enable.
  // Bit positions inside the auxiliary register.
  localparam int AUX_WDT_BIT = 0;  // Watchdog enable, read/write.
  localparam int AUX_LP_BIT  = 1;  // Low-power mode active, read only.
  // Value of the flags after a power-on reset.
  localparam logic [7:0] POR_FLAGS = 8'h02;
  // Timing figures.
  localparam int CLK_PERIOD_PS     = 4000;       // 250 MHz system clock.
  localparam int MCD_TIMEOUT_PS    = 100000000;  // 100 us of a stuck clock.
  localparam int WDT_DIV           = 12;         // Watchdog clock divider.
  localparam logic [3:0] WDT_LAST  = 4'(WDT_DIV - 1);
  localparam int HOLD_CYCLES       = 16;         // Least reset pulse width.
  localparam logic [4:0] HOLD_LAST = 5'(HOLD_CYCLES - 1);
  // Sequencer states.
  typedef enum logic [0:0] {
    RSC_RUN  = 1'b0,  // Device running.
    RSC_HOLD = 1'b1   // Device held in reset.
  } rsc_state_e;
  // Flash access conditions that may raise a flash error.
  typedef struct packed {
    logic write_enable;    // Flash writes enabled by software.
    logic write_attempt;   // Write or erase attempted this cycle.
    logic write_above;     // Write or erase target above lock byte.
    logic table_above;     // Code table read above lock byte.
    logic branch_above;    // Branch target above lock byte.
    logic security_block;  // Access refused by security settings.
  } rsc_flash_s;
  // Real-time-clock event conditions.
  typedef struct packed {
    logic osc_mon_en;   // Oscillator monitor enabled.
    logic clk_slow;     // Oscillator below its fail threshold.
    logic alarm_en;     // Alarm enabled.
    logic alarm_match;  // Timer equals the alarm match registers.
  } rsc_rtc_s;
endpackage

// ### verification/rsc_pin_model.sv
// Model of the outside circuitry that pulls the external reset pin low.
`timescale 1ns/1ps
module rsc_pin_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       pull_req,
  input  wire logic [7:0] pull_len,
  output logic            pin_reset_n
);
  logic [7:0] left_q;  // Cycles of low drive still to go.

  // A request pulls the pin low for pull_len cycles; the length must
  // outlast the hold time of the device or the pulse is never seen whole.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      left_q <= 8'h00;
    end else if (pull_req) begin
      left_q <= pull_len;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end

  // Outside a pull the pin idles high through its pull-up.
  assign pin_reset_n = (left_q == 8'h00);
endmodule

// ### verification/test_rsc_top.sv
// Self-checking testbench for the reset source control block.
`timescale 1ns/1ps
module test_rsc_top;
  localparam int MCD_N = 20;  // Short clock-loss timeout for simulation.
  logic                clk = 1'b0;
  logic                rstn = 1'b0;
  logic [9:0]          avs_address = 10'h000;
  logic                avs_read = 1'b0;
  logic                avs_write = 1'b0;
  logic [31:0]         avs_writedata = 32'h0;
  logic [3:0]          avs_byteenable = 4'hf;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  logic                pin_reset_n;
  logic                pull_req = 1'b0;
  logic                suspend_mode = 1'b0;
  logic                sleep_mode = 1'b0;
  logic                clock_monitor = 1'b0;
  logic                clk_hold = 1'b0;  // Freezes the monitored clock.
  logic                comparator_out = 1'b1;
  logic                comparator_wake_en = 1'b0;
  logic                watchdog_overflow = 1'b0;
  rsc_pkg::rsc_flash_s flash_access = '0;
  rsc_pkg::rsc_rtc_s   rtc_event = '0;
  logic                supply_monitor_on = 1'b0;
  logic                supply_level_status = 1'b1;
  logic                sys_reset_q;
  logic [7:0]          reset_flags_q;
  logic                watchdog_en_q;
  logic                watchdog_tick_q;
  int                  error_cnt = 0;
  int                  num_checks = 0;

  // Clock of 4 ns period.
  always #2 clk = ~clk;

  // The monitored clock toggles every cycle unless frozen on purpose.
  always @(posedge clk) begin
    if (!clk_hold) begin
      clock_monitor <= ~clock_monitor;
    end
  end

  rsc_top #(.MCD_CYCLES(MCD_N)) i_rsc_top (
    .clk(clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_reset_n(pin_reset_n), .suspend_mode(suspend_mode),
    .sleep_mode(sleep_mode), .clock_monitor(clock_monitor),
    .comparator_out(comparator_out),
    .comparator_wake_en(comparator_wake_en),
    .watchdog_overflow(watchdog_overflow), .flash_access(flash_access),
    .rtc_event(rtc_event), .supply_monitor_on(supply_monitor_on),
    .supply_level_status(supply_level_status), .sys_reset_q(sys_reset_q),
    .reset_flags_q(reset_flags_q), .watchdog_en_q(watchdog_en_q),
    .watchdog_tick_q(watchdog_tick_q));

  rsc_pin_model i_rsc_pin_model (
    .clk(clk), .rstn(rstn), .pull_req(pull_req), .pull_len(8'h1e),
    .pin_reset_n(pin_reset_n));

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // A wait that used up its bound is a mismatch and ends the run.
  task automatic timed_out();
    check(32'h0, 32'h1);
    stop_test();
  endtask

  // One Avalon access; the request is held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) timed_out();
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h0, d}, 4'hf, q);
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    check(q, {24'h0, exp});
  endtask

  // Puts every reset source except the pin and the watchdog overflow back into its harmless state.
  task automatic quiet();
    suspend_mode <= 1'b0;
    sleep_mode <= 1'b0;
    clk_hold <= 1'b0;
    comparator_out <= 1'b1;
    comparator_wake_en <= 1'b0;
    flash_access <= '0;
    rtc_event <= '0;
    supply_monitor_on <= 1'b0;
    supply_level_status <= 1'b1;
  endtask

  // Waits for a device reset, removes the cause and judges the recorded
  // cause once the device runs again; n returns the cycles to the reset.
  task automatic trip(input logic [7:0] exp, input int bound, output int n);
    int m;
    n = 0;
    m = 0;
    while (sys_reset_q !== 1'b1 && n < bound) begin
      @(posedge clk);
      n++;
    end
    if (n >= bound) timed_out();
    if (exp != 8'h01) check(pin_reset_n, 1'b1);
    quiet();
    while (sys_reset_q !== 1'b0 && m < 200) begin
      @(posedge clk);
      m++;
    end
    if (m >= 200) timed_out();
    check(reset_flags_q, exp);
    check(watchdog_en_q, 1'b1);
  endtask

  // Watches that no reset happens for a number of cycles.
  task automatic no_trip(input int cycles);
    logic seen;
    seen = 1'b0;
    repeat (cycles) begin
      @(posedge clk);
      if (sys_reset_q !== 1'b0) seen = 1'b1;
    end
    check(seen, 1'b0);
  endtask

  // Power-on values, an unmapped read and the watchdog tick period.
  task automatic t_reset_values();
    int n;
    rd(rsc_pkg::CAUSE_ADDR, 8'h02);
    rd(rsc_pkg::AUX_ADDR, 8'h01);
    rd(10'h000, 8'h00);
    n = 0;
    while (watchdog_tick_q !== 1'b1 && n < 30) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (watchdog_tick_q !== 1'b1 && n < 30);
    check(n, 12);
  endtask

  // Writes that must be ignored, then the software force.
  task automatic t_software();
    logic [31:0] q;
    int          n;
    bus(1'b1, rsc_pkg::CAUSE_ADDR, 32'h10, 4'he, q);
    wr(10'h000, 8'hff);
    no_trip(10);
    wr(rsc_pkg::CAUSE_ADDR, 8'h10);
    trip(8'h10, 10, n);
  endtask

  // Pin reset while running and while suspended.
  task automatic t_pin();
    int n;
    pull_req <= 1'b1;
    @(posedge clk);
    pull_req <= 1'b0;
    trip(8'h01, 10, n);
    suspend_mode <= 1'b1;
    pull_req <= 1'b1;
    @(posedge clk);
    pull_req <= 1'b0;
    trip(8'h01, 10, n);
  endtask

  // Clock-loss timeout, then suppression in sleep with the enable kept.
  task automatic t_clock_loss();
    int n;
    wr(rsc_pkg::CAUSE_ADDR, 8'h04);
    clk_hold <= 1'b1;
    trip(8'h04, 40, n);
    check(n >= MCD_N && n <= MCD_N + 4, 1'b1);
    wr(rsc_pkg::CAUSE_ADDR, 8'h04);
    sleep_mode <= 1'b1;
    clk_hold <= 1'b1;
    no_trip(2 * MCD_N);
    sleep_mode <= 1'b0;
    trip(8'h04, 40, n);
  endtask

  // Watchdog overflow ignored while suspended, acted on when awake.
  task automatic t_watchdog();
    int n;
    suspend_mode <= 1'b1;
    watchdog_overflow <= 1'b1;
    @(posedge clk);
    watchdog_overflow <= 1'b0;
    no_trip(5);
    check(watchdog_en_q, 1'b1);
    rd(rsc_pkg::AUX_ADDR, 8'h03);
    suspend_mode <= 1'b0;
    watchdog_overflow <= 1'b1;
    @(posedge clk);
    watchdog_overflow <= 1'b0;
    trip(8'h08, 10, n);
  endtask

  // Comparator enabled only once settled high; sleep needs the wake-up.
  task automatic t_comparator();
    int n;
    wr(rsc_pkg::CAUSE_ADDR, 8'h20);
    sleep_mode <= 1'b1;
    comparator_out <= 1'b0;
    no_trip(10);
    comparator_wake_en <= 1'b1;
    trip(8'h20, 10, n);
  endtask

  // Every illegal flash access, after one legal write.
  task automatic t_flash();
    logic [5:0] fv [5] = '{6'h38, 6'h04, 6'h02, 6'h01, 6'h10};
    int         n;
    supply_monitor_on <= 1'b1;
    flash_access <= rsc_pkg::rsc_flash_s'(6'h30);
    no_trip(5);
    for (int i = 0; i < 5; i++) begin
      flash_access <= rsc_pkg::rsc_flash_s'(fv[i]);
      trip(8'h40, 10, n);
    end
  endtask

  // Both clock events, ignored while disabled, acted on in sleep.
  task automatic t_rtc();
    logic [3:0] ev [2] = '{4'hc, 4'h3};
    int         n;
    for (int i = 0; i < 2; i++) begin
      rtc_event <= rsc_pkg::rsc_rtc_s'(ev[i]);
      sleep_mode <= 1'b1;
      no_trip(5);
      wr(rsc_pkg::CAUSE_ADDR, 8'h80);
      trip(8'h80, 10, n);
    end
  endtask

  // Supply monitor resets only when switched on and selected.
  task automatic t_supply();
    int n;
    wr(rsc_pkg::CAUSE_ADDR, 8'h02);
    supply_level_status <= 1'b0;
    no_trip(10);
    supply_level_status <= 1'b1;
    supply_monitor_on <= 1'b1;
    wr(rsc_pkg::CAUSE_ADDR, 8'h02);
    supply_level_status <= 1'b0;
    trip(8'h02, 10, n);
  endtask

  // Main sequence: ten cycles of reset, then every scenario in turn.
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset_values();
    t_software();
    t_pin();
    t_clock_loss();
    t_watchdog();
    t_comparator();
    t_flash();
    t_rtc();
    t_supply();
    stop_test();
  end
endmodule
